// >>> inc/bsil_pkg.sv
// Shared constants and types for the bus slave interrupt logic
package bsil_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int BSIL_LINES = 8;       // Shared interrupt request lines
  localparam int BSIL_DATA_W = 8;      // Data byte on the bus
  localparam int BSIL_CODE_W = 3;      // Interrupt code on address lines
  localparam int BSIL_IOADR_W = 8;     // I/O address width
  localparam int BSIL_VEC_W = 16;      // Assembled service address

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BSIL_CLK_NS = 10;     // Clock period in ns
  localparam int BSIL_XACK_NS = 300;   // Least command-to-acknowledge time
  // Least time rounds up to whole cycles
  localparam int BSIL_XACK_CYC = (BSIL_XACK_NS + BSIL_CLK_NS - 1)
                                 / BSIL_CLK_NS;
  localparam int BSIL_FIRST_CYC = 4;   // Length of the first acknowledge
  localparam int BSIL_TIMEOUT_CYC = 64; // Master gives up waiting

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BSIL_BYTE_RST = 8'h00;
  localparam logic [7:0] BSIL_STATUS_PAD = 8'h00;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    BSIL_S_IDLE   = 3'b001,  // Waiting for a first acknowledge
    BSIL_S_FROZEN = 3'b010,  // Priority frozen, next ack returns byte
    BSIL_S_SECOND = 3'b100   // Three-ack: waiting for the high byte
  } bsil_slave_e;

  typedef enum logic [2:0]
  {
    BSIL_M_IDLE = 3'b001,    // No operation running
    BSIL_M_CMD  = 3'b010,    // Command asserted on the bus
    BSIL_M_GAP  = 3'b100     // Command released between cycles
  } bsil_master_e;

endpackage : bsil_pkg

// >>> inc/bsil_if.sv
// Shared bus between the master and the interrupting slave
`timescale 1ns/1ps
`default_nettype none

interface bsil_if;
  import bsil_pkg::*;

  // Master drives these
  logic inta;                          // Interrupt acknowledge command
  logic override;                      // Bus locked for the ack sequence
  logic io_rd;                         // local_io_read command
  logic io_wr;                         // local_io_write command
  logic [BSIL_IOADR_W-1:0] io_adr;     // I/O address
  logic [BSIL_CODE_W-1:0] code;        // Interrupt code on ADR8-ADRA
  // Slave drives these
  logic [BSIL_LINES-1:0] irq_oe;       // Open-collector pull per line
  logic [BSIL_DATA_W-1:0] dat_out;     // Slave data byte
  logic dat_oe;                        // Slave drives data lines
  logic xack;                          // Transfer acknowledge
  // Resolved levels, high means asserted
  logic [BSIL_LINES-1:0] irq;
  logic [BSIL_DATA_W-1:0] dat;

  // Open-collector lines are asserted by any puller
  assign irq = irq_oe;
  // Undriven data lines float to all ones
  assign dat = dat_oe ? dat_out : '1;

  modport slave
  (
    input inta, override, io_rd, io_wr, io_adr, code,
    output irq_oe, dat_out, dat_oe, xack
  );

  modport master
  (
    output inta, override, io_rd, io_wr, io_adr, code,
    input irq, dat, xack
  );

endinterface : bsil_if

`default_nettype wire

// >>> hw/bsil_ack_timer.sv
// Delay from command to transfer acknowledge
`timescale 1ns/1ps
`default_nettype none

module bsil_ack_timer
  import bsil_pkg::*;
#(
  parameter int DELAY = BSIL_XACK_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command and acknowledge
  input wire logic i_cmd,
  output logic o_ack
);

  localparam int CW = $clog2(DELAY + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY - 1);

  logic [CW-1:0] count;       // Cycles since the command began
  logic [CW-1:0] next_count;
  logic ack;                  // Acknowledge flop
  logic next_ack;

  // --------------------------------------------------------------
  // Counter: cleared as soon as the command is removed
  // --------------------------------------------------------------
  always_comb
  begin
    next_count = count;
    next_ack = 1'b0;
    if (!i_cmd)
    begin
      next_count = '0;
    end
    else if (count == LAST)
    begin
      next_ack = 1'b1;        // Holds until the command drops
    end
    else
    begin
      next_count = count + CW'(1);
    end
  end

  // Registers only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= '0;
      ack <= 1'b0;
    end
    else
    begin
      count <= next_count;
      ack <= next_ack;
    end
  end

  assign o_ack = ack;

endmodule : bsil_ack_timer

`default_nettype wire

// >>> hw/bsil_slave.sv
// Slave end: direct-line and vectored interrupt logic
// Functional notes
// - Strobe latches direct interrupt until software clears
// - Latched request pulls one selectable bus line
// - Addressed I/O read drives status bit
// - I/O write same address clears direct request
// - Vectored request uses same line buffering
// - Two acks; first ack freezes priority
// - Master locks bus during acknowledge sequence
// - Drive data only when code matches number
// - Drive restart byte, then assert acknowledge
// - Master keeps number valid after first ack
// - Three-ack returns one byte per ack
// - Acknowledge each returned byte separately
// - Master joins two bytes into address
// - One acknowledge variant for whole system
`timescale 1ns/1ps
`default_nettype none

module bsil_slave
  import bsil_pkg::*;
#(
  parameter int XACK_DELAY = BSIL_XACK_CYC
)
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Shared bus
  bsil_if.slave bus,
  // Direct-line request
  input wire logic I_IRQ_STROBE,
  input wire logic [2:0] I_LINE_SEL,
  input wire logic [BSIL_IOADR_W-1:0] I_IO_ADDR,
  // Vectored request
  input wire logic I_VEC_REQ,
  input wire logic I_THREE_ACK,
  input wire logic [BSIL_CODE_W-1:0] I_SLAVE_NUM,
  input wire logic [BSIL_DATA_W-1:0] I_RESTART_LO,
  input wire logic [BSIL_DATA_W-1:0] I_RESTART_HI,
  // Status
  output logic O_DIRECT_PEND,
  output logic O_VEC_PEND,
  output logic O_VEC_SERVED
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  logic strobe_q;               // Previous strobe level
  logic next_strobe_q;
  logic inta_q;                 // Previous acknowledge level
  logic next_inta_q;
  logic direct_pend;            // direct_line_interrupt latch
  logic next_direct_pend;
  logic vec_pend;               // vectored_interrupt request latch
  logic next_vec_pend;
  logic frozen;                 // Request seen at the first ack
  logic next_frozen;
  logic served;                 // One-cycle pulse on last byte
  logic next_served;
  bsil_slave_e state;
  bsil_slave_e next_state;
  logic resp;                   // This slave answers the current ack
  logic next_resp;
  logic [BSIL_DATA_W-1:0] resp_byte;
  logic [BSIL_DATA_W-1:0] next_resp_byte;
  logic [BSIL_LINES-1:0] irq_oe;
  logic [BSIL_LINES-1:0] next_irq_oe;
  logic [BSIL_DATA_W-1:0] dat_out;
  logic [BSIL_DATA_W-1:0] next_dat_out;
  logic dat_oe;
  logic next_dat_oe;

  // Decoded strobes from the bus and user side
  logic strobe_rise;            // Local request edge
  logic inta_rise;              // Start of an acknowledge
  logic rd_sel;                 // Status read to our address
  logic wr_sel;                 // Clear write to our address
  logic code_match;             // Code on address lines is ours
  logic timer_cmd;              // Any command we answer
  logic xack;

  // Address compare is used for both read and write
  function automatic logic addr_hit(input logic [BSIL_IOADR_W-1:0] a,
                                    input logic [BSIL_IOADR_W-1:0] b);
    addr_hit = (a == b);
  endfunction : addr_hit

  assign strobe_rise = I_IRQ_STROBE && !strobe_q;
  assign inta_rise = bus.inta && !inta_q;
  assign rd_sel = bus.io_rd && addr_hit(bus.io_adr, I_IO_ADDR);
  assign wr_sel = bus.io_wr && addr_hit(bus.io_adr, I_IO_ADDR);
  assign code_match = (bus.code == I_SLAVE_NUM);

  // --------------------------------------------------------------
  // Direct-line latch and shared line driver
  // --------------------------------------------------------------
  // The set wins over a clear in the same cycle so that a request
  // arriving while software clears the previous one is kept.
  always_comb
  begin
    next_strobe_q = I_IRQ_STROBE;
    next_direct_pend = direct_pend;
    if (wr_sel)
    begin
      next_direct_pend = 1'b0;
    end
    if (strobe_rise)
    begin
      next_direct_pend = 1'b1;
    end
    // Both sources pull the one selected line
    next_irq_oe = '0;
    next_irq_oe[I_LINE_SEL] = next_direct_pend || next_vec_pend;
  end

  // Registers only
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      strobe_q <= 1'b0;
      direct_pend <= 1'b0;
      irq_oe <= '0;
    end
    else
    begin
      strobe_q <= next_strobe_q;
      direct_pend <= next_direct_pend;
      irq_oe <= next_irq_oe;
    end
  end

  // --------------------------------------------------------------
  // Vectored acknowledge sequencer
  // --------------------------------------------------------------
  // Only the rising edge of each acknowledge moves the state, so a
  // long acknowledge counts once. The variant input must match the
  // master's: a mixed system would hand out the wrong byte.
  always_comb
  begin
    next_inta_q = bus.inta;
    next_state = state;
    next_vec_pend = vec_pend;
    next_frozen = frozen;
    next_resp = resp && bus.inta;     // Answer ends with the command
    next_resp_byte = resp_byte;
    next_served = 1'b0;
    if (I_VEC_REQ)
    begin
      next_vec_pend = 1'b1;
    end
    if (inta_rise)
    begin
      unique case (state)
        BSIL_S_IDLE:
        begin
          // First ack: freeze, never drive the data lines
          next_frozen = vec_pend;
          next_state = BSIL_S_FROZEN;
        end
        BSIL_S_FROZEN:
        begin
          if (frozen && code_match)
          begin
            next_resp = 1'b1;
            next_resp_byte = I_RESTART_LO;
          end
          if (I_THREE_ACK)
          begin
            next_state = BSIL_S_SECOND;
          end
          else
          begin
            next_state = BSIL_S_IDLE;
            if (frozen && code_match)
            begin
              next_vec_pend = I_VEC_REQ;
              next_served = 1'b1;
            end
          end
        end
        BSIL_S_SECOND:
        begin
          if (frozen && code_match)
          begin
            next_resp = 1'b1;
            next_resp_byte = I_RESTART_HI;
            next_vec_pend = I_VEC_REQ;
            next_served = 1'b1;
          end
          next_state = BSIL_S_IDLE;
        end
        default:
        begin
          next_state = BSIL_S_IDLE;
        end
      endcase
    end
  end

  // Registers only
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      inta_q <= 1'b0;
      state <= BSIL_S_IDLE;
      vec_pend <= 1'b0;
      frozen <= 1'b0;
      resp <= 1'b0;
      resp_byte <= BSIL_BYTE_RST;
      served <= 1'b0;
    end
    else
    begin
      inta_q <= next_inta_q;
      state <= next_state;
      vec_pend <= next_vec_pend;
      frozen <= next_frozen;
      resp <= next_resp;
      resp_byte <= next_resp_byte;
      served <= next_served;
    end
  end

  // --------------------------------------------------------------
  // Data drivers and acknowledge
  // --------------------------------------------------------------
  // Drivers come on one cycle after selection, well before the
  // delayed acknowledge, so the byte is settled when XACK rises.
  always_comb
  begin
    next_dat_oe = 1'b0;
    next_dat_out = BSIL_BYTE_RST;
    if (next_resp)
    begin
      next_dat_oe = 1'b1;
      next_dat_out = next_resp_byte;
    end
    else if (rd_sel)
    begin
      next_dat_oe = 1'b1;
      next_dat_out = {BSIL_STATUS_PAD[7:1], direct_pend};
    end
  end

  // Registers only
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      dat_oe <= 1'b0;
      dat_out <= BSIL_BYTE_RST;
    end
    else
    begin
      dat_oe <= next_dat_oe;
      dat_out <= next_dat_out;
    end
  end

  // Live command gates the answer, so xack drops one cycle after it and never
  // leaks into the next acknowledge of a sequence
  assign timer_cmd = (resp && bus.inta) || rd_sel || wr_sel;

  bsil_ack_timer #(
    .DELAY(XACK_DELAY)
  ) u_ack (
    .clk(I_CLOCK),
    .rst(I_RESET),
    .i_cmd(timer_cmd),
    .o_ack(xack)
  );

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign bus.irq_oe = irq_oe;
  assign bus.dat_out = dat_out;
  assign bus.dat_oe = dat_oe;
  assign bus.xack = xack;
  assign O_DIRECT_PEND = direct_pend;
  assign O_VEC_PEND = vec_pend;
  assign O_VEC_SERVED = served;

endmodule : bsil_slave

`default_nettype wire

// >>> hw/bsil_master.sv
// Master end: I/O status access and interrupt acknowledge sequence
`timescale 1ns/1ps
`default_nettype none

module bsil_master
  import bsil_pkg::*;
#(
  parameter int FIRST_CYC = BSIL_FIRST_CYC,
  parameter int TIMEOUT = BSIL_TIMEOUT_CYC
)
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Shared bus
  bsil_if.master bus,
  // User requests, one-cycle pulses taken in idle
  input wire logic I_ACK_START,
  input wire logic I_THREE_ACK,
  input wire logic [BSIL_CODE_W-1:0] I_CODE,
  input wire logic I_IO_RD,
  input wire logic I_IO_WR,
  input wire logic [BSIL_IOADR_W-1:0] I_IO_ADDR,
  // Results
  output logic [BSIL_LINES-1:0] O_IRQ,
  output logic [BSIL_VEC_W-1:0] O_VECTOR,
  output logic [BSIL_DATA_W-1:0] O_RDATA,
  output logic O_DONE,
  output logic O_TIMEOUT,
  output logic O_BUSY
);

  localparam int TW = $clog2(TIMEOUT + 1);

  bsil_master_e state;
  bsil_master_e next_state;
  logic [TW-1:0] cnt;            // Cycles in the current command
  logic [TW-1:0] next_cnt;
  logic [1:0] idx;               // Acknowledge number in sequence
  logic [1:0] next_idx;
  logic is_ack, next_is_ack;     // Sequence is an acknowledge
  logic is_rd, next_is_rd;       // Single I/O read
  logic three, next_three;
  logic [BSIL_CODE_W-1:0] code, next_code;
  logic [BSIL_IOADR_W-1:0] adr, next_adr;
  logic [BSIL_VEC_W-1:0] vec, next_vec;
  logic [BSIL_DATA_W-1:0] rdata, next_rdata;
  logic [BSIL_LINES-1:0] irq, next_irq;
  logic done, next_done;
  logic tout, next_tout;

  // --------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------
  // The first acknowledge belongs to the master's own controller and
  // has a fixed length; later ones wait for the slave's acknowledge.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_idx = idx;
    next_is_ack = is_ack;
    next_is_rd = is_rd;
    next_three = three;
    next_code = code;
    next_adr = adr;
    next_vec = vec;
    next_rdata = rdata;
    next_irq = bus.irq;
    next_done = 1'b0;
    next_tout = 1'b0;
    unique case (state)
      BSIL_M_IDLE:
      begin
        next_cnt = '0;
        next_idx = 2'h0;
        next_three = I_THREE_ACK;     // One variant per system
        next_code = I_CODE;
        next_adr = I_IO_ADDR;
        next_is_ack = I_ACK_START;
        next_is_rd = I_IO_RD && !I_ACK_START;
        if (I_ACK_START || I_IO_RD || I_IO_WR)
        begin
          next_vec = '0;
          next_state = BSIL_M_CMD;
        end
      end
      BSIL_M_CMD:
      begin
        next_cnt = cnt + TW'(1);
        if (is_ack && idx == 2'h0)
        begin
          if (cnt == TW'(FIRST_CYC - 1))
          begin
            next_state = BSIL_M_GAP;
          end
        end
        else if (bus.xack || cnt == TW'(TIMEOUT - 1))
        begin
          next_tout = !bus.xack;
          if (!is_ack)
          begin
            next_rdata = bus.dat;
          end
          else if (idx == 2'h2)
          begin
            next_vec[15:8] = bus.dat;
          end
          else
          begin
            next_vec[7:0] = bus.dat;
          end
          next_state = BSIL_M_GAP;
        end
      end
      BSIL_M_GAP:
      begin
        // One idle cycle lets the slave see the command drop
        next_cnt = '0;
        if (is_ack && idx != (three ? 2'h2 : 2'h1))
        begin
          next_idx = idx + 2'h1;
          next_state = BSIL_M_CMD;
        end
        else
        begin
          next_done = 1'b1;
          next_is_ack = 1'b0;
          next_state = BSIL_M_IDLE;
        end
      end
      default:
      begin
        next_state = BSIL_M_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      state <= BSIL_M_IDLE;
      cnt <= '0;
      idx <= 2'h0;
      is_ack <= 1'b0;
      is_rd <= 1'b0;
      three <= 1'b0;
      code <= '0;
      adr <= '0;
      vec <= '0;
      rdata <= BSIL_BYTE_RST;
      irq <= '0;
      done <= 1'b0;
      tout <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      is_ack <= next_is_ack;
      is_rd <= next_is_rd;
      three <= next_three;
      code <= next_code;
      adr <= next_adr;
      vec <= next_vec;
      rdata <= next_rdata;
      irq <= next_irq;
      done <= next_done;
      tout <= next_tout;
    end
  end

  // --------------------------------------------------------------
  // Bus drive
  // --------------------------------------------------------------
  assign bus.inta = (state == BSIL_M_CMD) && is_ack;
  assign bus.override = is_ack;
  assign bus.io_rd = (state == BSIL_M_CMD) && !is_ack && is_rd;
  assign bus.io_wr = (state == BSIL_M_CMD) && !is_ack && !is_rd;
  assign bus.io_adr = adr;
  // Code valid from the second acknowledge on and held
  assign bus.code = (is_ack && idx != 2'h0) ? code : '0;

  assign O_IRQ = irq;
  assign O_VECTOR = vec;
  assign O_RDATA = rdata;
  assign O_DONE = done;
  assign O_TIMEOUT = tout;
  assign O_BUSY = is_ack;

endmodule : bsil_master

`default_nettype wire

// >>> verification/bsil_checker.sv
// Bus-side assertions for the interrupt slave and its master
`timescale 1ns/1ps
`default_nettype none

module bsil_checker
  import bsil_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Master commands
  input wire logic inta,
  input wire logic override,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [BSIL_CODE_W-1:0] code,
  // Slave answers
  input wire logic [BSIL_LINES-1:0] irq_oe,
  input wire logic dat_oe,
  input wire logic xack,
  input wire logic [BSIL_DATA_W-1:0] dat
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [1:0] n_inta;      // Acknowledges begun under the current lock
  logic [1:0] next_n_inta;
  logic inta_d;            // Acknowledge one cycle ago
  logic next_inta_d;
  logic cmd;               // Any command on the bus
  assign cmd = inta | io_rd | io_wr;

  // Count acknowledge rises; saturates so a runaway master stays visible
  always_comb
  begin
    next_inta_d = inta;
    next_n_inta = n_inta;
    if (!override)
      next_n_inta = 2'h0;
    else if (inta && !inta_d && n_inta != 2'h3)
      next_n_inta = n_inta + 2'h1;
  end

  // Register only
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      n_inta <= 2'h0;
      inta_d <= 1'b0;
    end
    else
    begin
      n_inta <= next_n_inta;
      inta_d <= next_inta_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);

  a_first_ack_quiet: assert property (
    override && n_inta <= 2'h1 |-> !dat_oe && !xack)
    else $error("slave answered the first acknowledge");
  a_drive_on_cmd: assert property (
    dat_oe |-> $past(inta || io_rd))
    else $error("data driven without a read or acknowledge");
  a_byte_then_ack: assert property (
    $rose(xack) && inta |-> $past(dat_oe, 2))
    else $error("acknowledge came before the data byte");
  a_ack_late: assert property (
    $rose(xack) |-> $past(cmd, 20))
    else $error("acknowledge came too soon after the command");
  a_ack_release: assert property (
    $fell(cmd) |=> !xack)
    else $error("acknowledge outlived the command");
  a_ack_fresh: assert property (
    $rose(inta) |-> !xack)
    else $error("acknowledge carried into the next byte");
  a_one_line: assert property (
    $onehot0(irq_oe))
    else $error("more than one request line pulled");
  a_status_byte: assert property (
    io_rd && dat_oe |-> dat[7:1] == 7'h00)
    else $error("status byte has stray bits");
  a_lock_held: assert property (
    inta |-> override)
    else $error("acknowledge without bus lock");
  a_code_held: assert property (
    inta && inta_d |-> $stable(code))
    else $error("interrupt code moved during acknowledge");

  // Main scenarios reached
  c_three_ack: cover property (n_inta == 2'h3 && $rose(xack));
  c_io_read: cover property (io_rd && xack);
  c_io_write: cover property (io_wr && xack);
endmodule : bsil_checker

`default_nettype wire

// >>> verification/bsil_test.sv
// Self-checking bench: master and slave joined over the shared bus
`timescale 1ns/1ps
`default_nettype none

module bsil_test
  import bsil_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  localparam logic [7:0] SADR = 8'h40;  // Slave I/O address
  localparam logic [2:0] SNUM = 3'h5;   // Slave interrupt number
  typedef struct packed
  {
    logic three;                 // Three-acknowledge variant
    logic [2:0] code;            // Code the master sends
    logic [7:0] lo;              // Restart low byte
    logic [7:0] hi;              // Restart high byte
    logic ok;                    // Slave should answer
    logic [15:0] ev;             // Expected vector
  } bsil_row_s;
  bsil_row_s rows [8] = '{
    '{1'b0, 3'h5, 8'h3c, 8'h00, 1'b1, 16'h003c},
    '{1'b1, 3'h5, 8'h12, 8'h34, 1'b1, 16'h3412},
    '{1'b0, 3'h2, 8'h55, 8'h66, 1'b0, 16'h0000},
    '{1'b1, 3'h5, 8'ha5, 8'h5a, 1'b1, 16'h5aa5},
    '{1'b0, 3'h5, 8'hff, 8'hee, 1'b1, 16'h00ff},
    '{1'b1, 3'h0, 8'h11, 8'h22, 1'b0, 16'h0000},
    '{1'b1, 3'h5, 8'h00, 8'hff, 1'b1, 16'hff00},
    '{1'b0, 3'h7, 8'h81, 8'h18, 1'b0, 16'h0000}};
  logic clk, rst, strobe, vreq, three, ack, rd, wr;
  logic [2:0] sel, code;
  logic [7:0] addr, lo, hi, irq, rdata;
  logic [15:0] vec;
  logic dpend, vpend, done, tout, busy, served;
  logic saw_oe, got_to, vp, saw_sv; // Data, timeout, vector pend, served
  int n_mismatch, samples_checked, cyc;

  bsil_if bsil_if_i ();
  bsil_slave bsil_slave_i (.I_CLOCK(clk), .I_RESET(rst),
    .bus(bsil_if_i.slave), .I_IRQ_STROBE(strobe), .I_LINE_SEL(sel),
    .I_IO_ADDR(SADR), .I_VEC_REQ(vreq), .I_THREE_ACK(three),
    .I_SLAVE_NUM(SNUM), .I_RESTART_LO(lo), .I_RESTART_HI(hi),
    .O_DIRECT_PEND(dpend), .O_VEC_PEND(vpend), .O_VEC_SERVED(served));
  bsil_master bsil_master_i (.I_CLOCK(clk), .I_RESET(rst),
    .bus(bsil_if_i.master), .I_ACK_START(ack), .I_THREE_ACK(three),
    .I_CODE(code), .I_IO_RD(rd), .I_IO_WR(wr), .I_IO_ADDR(addr),
    .O_IRQ(irq), .O_VECTOR(vec), .O_RDATA(rdata), .O_DONE(done),
    .O_TIMEOUT(tout), .O_BUSY(busy));
  bsil_checker bsil_checker_i (.I_CLOCK(clk), .I_RESET(rst),
    .inta(bsil_if_i.inta), .override(bsil_if_i.override),
    .io_rd(bsil_if_i.io_rd), .io_wr(bsil_if_i.io_wr),
    .code(bsil_if_i.code), .irq_oe(bsil_if_i.irq_oe),
    .dat_oe(bsil_if_i.dat_oe), .xack(bsil_if_i.xack),
    .dat(bsil_if_i.dat));

  // Clock, and a ceiling far above the ~1700 cycles the run needs
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // Any data drive by the slave during an operation
  always @(posedge clk)
    if (bsil_if_i.dat_oe === 1'b1)
      saw_oe = 1'b1;
  // Service pulse from the slave during an operation
  always @(posedge clk)
    if (served === 1'b1)
      saw_sv = 1'b1;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // One master operation: 0 acknowledge, 1 read, 2 write
  task go(input int k, input logic [7:0] a, input logic [2:0] c);
    int n;
    @(posedge clk);
    ack <= (k == 0);
    rd <= (k == 1);
    wr <= (k == 2);
    addr <= a;
    code <= c;
    saw_oe = 1'b0;
    got_to = 1'b0;
    saw_sv = 1'b0;
    @(posedge clk);
    {ack, rd, wr} <= 3'b000;
    for (n = 0; n < 200; n++)
    begin
      @(negedge clk);
      if (tout === 1'b1)
        got_to = 1'b1;
      if (done === 1'b1 || tout === 1'b1)
        break;
    end
    // A wait that runs out is a hang
    if (n == 200)
      n_mismatch++;
    // Bounded wait for the lock to drop after a timed-out sequence
    for (n = 0; n < 200 && busy !== 1'b0; n++)
      @(negedge clk);
    if (busy !== 1'b0)
      n_mismatch++;
  endtask : go

  // Pulse the strobe or the vectored request, let the line settle
  task pulse(input bit v);
    @(posedge clk);
    if (v)
      vreq <= 1'b1;
    else
      strobe <= 1'b1;
    @(posedge clk);
    {vreq, strobe} <= 2'b00;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : pulse

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {strobe, vreq, three, ack, rd, wr} = 6'h00;
    {sel, code, addr, lo, hi} = '0;
    {saw_oe, got_to, vp, saw_sv} = 4'h0;
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Every line, both variants, selected and unselected codes
    foreach (rows[i])
    begin
      @(posedge clk);
      sel <= i[2:0];
      three <= rows[i].three;
      lo <= rows[i].lo;
      hi <= rows[i].hi;
      pulse(1'b0);
      chk(irq, 8'h01 << i);
      go(1, SADR, 3'h0);
      chk(rdata, 8'h01);
      go(2, SADR, 3'h0);
      chk(dpend, 1'b0);
      chk(irq, vp ? (8'h01 << i) : 8'h00);
      go(1, SADR, 3'h0);
      chk(rdata, 8'h00);
      pulse(1'b1);
      vp = 1'b1;
      chk(irq, 8'h01 << i);
      go(0, 8'h00, rows[i].code);
      chk(got_to, !rows[i].ok);
      chk(saw_oe, rows[i].ok);
      chk(saw_sv, rows[i].ok);
      if (rows[i].ok)
        chk(vec, rows[i].ev);
      vp = vp && !rows[i].ok;
      chk(vpend, vp);
    end
    // Read at a foreign address goes unanswered
    go(1, SADR + 8'h01, 3'h0);
    chk({got_to, saw_oe}, 2'b10);
    // Reset in mid-run drops every request
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    vp = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({dpend, vpend, busy, irq}, 11'h000);
    // Acknowledge with nothing pending: no driver may answer
    go(0, 8'h00, SNUM);
    chk({got_to, saw_oe, saw_sv}, 3'b100);
    // Strobe held high latches once; the clear still wins
    @(posedge clk);
    strobe <= 1'b1;
    go(2, SADR, 3'h0);
    chk(dpend, 1'b0);
    go(1, SADR, 3'h0);
    chk(rdata, 8'h00);
    strobe <= 1'b0;
    end_sim();
  end
endmodule : bsil_test

`default_nettype wire
